/* sapd_bit_count.sv */
/*
  Counts the one bits of a credit vector.
  Purely combinational; the width is a parameter.
*/
`timescale 1ns/1ps
module sapd_bit_count #(
  parameter int WIDTH = 128,
  parameter int CNT_W = 8
) (
  input  wire logic [WIDTH-1:0] vec_i,
  output logic      [CNT_W-1:0] count_o
);

  always_comb begin
    count_o = '0;
    for (int i = 0; i < WIDTH; i++) begin
      count_o = count_o + CNT_W'(vec_i[i]);
    end
  end

endmodule : sapd_bit_count

/* sapd_field_decode.sv */
/*
  Splits one 16-bit slot configuration word into its policy terms.
  Purely combinational; assumes the caller registers what it needs.
*/
`timescale 1ns/1ps
module sapd_field_decode (
  input  wire logic [15:0] cfg_i,
  output logic             secret_o,
  output logic             enc_read_o,
  output logic             use_limit_o,
  output logic             verify_only_o,
  output logic [3:0]       wkey_o,
  output logic [3:0]       rkey_o,
  output logic             wr_always_o,
  output logic             wr_never_o,
  output logic             wr_encrypt_o,
  output logic             dk_allowed_o,
  output logic             dk_create_o,
  output logic             dk_mac_req_o,
  output logic             copy_src_o
);
  import sapd_pkg::*;

  wire logic [3:0] wp = cfg_i[WP_HI:WP_LO];

  // Write and derive terms come from the same field independently.
  assign wr_always_o   = (wp[3:1] == 3'b000);
  assign wr_encrypt_o  = cfg_i[WP_ENC_BIT];
  assign wr_never_o    = !wr_always_o && !wr_encrypt_o;
  assign dk_allowed_o  = cfg_i[WP_DK_BIT];
  assign dk_create_o   = cfg_i[WP_CREATE_BIT];
  assign dk_mac_req_o  = cfg_i[WP_HI];
  assign wkey_o        = cfg_i[WKEY_HI:WKEY_LO];
  assign secret_o      = cfg_i[SECRET_BIT];
  assign enc_read_o    = cfg_i[ENC_READ_BIT];
  assign use_limit_o   = cfg_i[USE_LIMIT_BIT];
  assign verify_only_o = cfg_i[VERIFY_ONLY_BIT];
  assign rkey_o        = cfg_i[RKEY_HI:RKEY_LO];
  assign copy_src_o    = (cfg_i[RKEY_HI:RKEY_LO] == 4'h0);

endmodule : sapd_field_decode

/* sapd_host_model.sv */
/*
  Host model that issues one decoded command at a time to the policy decoder.
  Assumes the decoder takes a command at a rising edge and answers one cycle later.
*/
`timescale 1ns/1ps
module sapd_host_model (
  input  wire logic          clk_i,
  output logic               cmd_valid_o,
  output sapd_pkg::sapd_op_t cmd_op_o,
  output logic [3:0]         cmd_slot_o,
  output logic               cmd_long_o,
  output logic               cmd_enc_o,
  output logic               cmd_mac_ok_o,
  output logic               cmd_vnext_o,
  output logic [4:0]         cmd_word_o,
  output logic [31:0]        cmd_wdata_o
);
  import sapd_pkg::*;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = OP_READ;
    {cmd_slot_o, cmd_long_o, cmd_enc_o, cmd_mac_ok_o, cmd_vnext_o, cmd_word_o, cmd_wdata_o} = '0;
  end

  // Drives at a falling edge, holds through the taking edge, then drops valid and inverts the slot, word and data lines.
  task automatic send(input sapd_op_t op, input logic [3:0] slot, input logic [3:0] fl,
                      input logic [4:0] word, input logic [31:0] wdata);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_slot_o = slot;
    {cmd_long_o, cmd_enc_o, cmd_mac_ok_o, cmd_vnext_o} = fl;
    cmd_word_o = word;
    cmd_wdata_o = wdata;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    {cmd_slot_o, cmd_word_o, cmd_wdata_o} = ~{cmd_slot_o, cmd_word_o, cmd_wdata_o};
  endtask : send
endmodule : sapd_host_model

/* sapd_pkg.sv */
/*
  Shared constants for the slot access policy decoder: configuration word
  addresses, slot-configuration field positions, lock values, reset values
  and the command codes.
  Assumes the command framing logic presents one decoded command at a time.
*/
package sapd_pkg;

  localparam int          NUM_SLOTS       = 16;
  localparam int          LIMITED_SLOTS   = 8;
  localparam int          CREDIT_W        = 128;
  localparam logic [3:0]  LAST_USE_SLOT   = 4'hf;

  localparam logic [7:0]  SLOT_CFG_OFFSET = 8'h14;
  localparam logic [4:0]  W_SLOT_FIRST    = 5'h05;
  localparam logic [4:0]  W_SLOT_LAST     = 5'h0c;
  localparam logic [4:0]  W_CREDIT_FIRST  = 5'h0d;
  localparam logic [4:0]  W_CREDIT_LAST   = 5'h10;
  localparam logic [4:0]  W_LASTUSE_FIRST = 5'h11;
  localparam logic [4:0]  W_LASTUSE_LAST  = 5'h14;
  localparam logic [4:0]  W_LOCK          = 5'h15;

  localparam int          WP_HI           = 15;
  localparam int          WP_LO           = 12;
  localparam int          WP_ENC_BIT      = 14;
  localparam int          WP_DK_BIT       = 13;
  localparam int          WP_CREATE_BIT   = 12;
  localparam int          WKEY_HI         = 11;
  localparam int          WKEY_LO         = 8;
  localparam int          SECRET_BIT      = 7;
  localparam int          ENC_READ_BIT    = 6;
  localparam int          USE_LIMIT_BIT   = 5;
  localparam int          VERIFY_ONLY_BIT = 4;
  localparam int          RKEY_HI         = 3;
  localparam int          RKEY_LO         = 0;

  localparam logic [7:0]  LOCK_OPEN       = 8'h55;
  localparam logic [7:0]  LOCK_SHUT       = 8'h00;

  localparam logic [15:0] SLOT_CFG_RST    = 16'h0000;
  localparam logic [7:0]  CREDIT_RST      = 8'hff;
  localparam logic [31:0] LASTUSE_RST     = 32'hffffffff;

  typedef enum logic [3:0] {
    OP_READ      = 4'h0,
    OP_WRITE     = 4'h1,
    OP_DERIVE    = 4'h2,
    OP_VERIFY    = 4'h3,
    OP_DIGEST    = 4'h4,
    OP_MAC       = 4'h5,
    OP_COPY      = 4'h6,
    OP_CFG_READ  = 4'h7,
    OP_CFG_WRITE = 4'h8,
    OP_LOCK_CFG  = 4'h9,
    OP_LOCK_DATA = 4'ha
  } sapd_op_t;

endpackage : sapd_pkg

/* sapd_top.sv */
/*
  Slot access policy decoder: holds the slot configuration words, use
  credits and lock bytes, and grants or refuses each decoded command.
  Assumes command framing, hashing and MAC checking sit outside and report
  their outcome on the command inputs in the cycle of CMD_VALID_I.
*/
`timescale 1ns/1ps
module sapd_top (
  input  wire logic              MCLK_I,
  input  wire logic              SRST_I,
  input  wire logic              CMD_VALID_I,
  input  wire sapd_pkg::sapd_op_t CMD_OP_I,
  input  wire logic [3:0]        CMD_SLOT_I,
  input  wire logic              CMD_LONG_I,
  input  wire logic              CMD_ENCRYPTED_I,
  input  wire logic              CMD_MAC_OK_I,
  input  wire logic              CMD_VERIFY_NEXT_I,
  input  wire logic [4:0]        CMD_WORD_I,
  input  wire logic [31:0]       CMD_WDATA_I,
  output logic                   RSP_VALID_O,
  output logic                   RSP_GRANT_O,
  output logic                   RSP_ERROR_O,
  output logic [3:0]             RSP_KEY_SLOT_O,
  output logic                   RSP_MAC_REQ_O,
  output logic                   RSP_CREATE_O,
  output logic [7:0]             RSP_USES_LEFT_O,
  output logic [31:0]            RSP_RDATA_O,
  output logic                   DATA_LOCKED_O,
  output logic                   CONFIG_LOCKED_O
);
  import sapd_pkg::*;

  logic [15:0]         slot_cfg_reg [NUM_SLOTS];
  logic [7:0]          credit_reg   [LIMITED_SLOTS];
  logic [31:0]         last_use_reg [4];
  logic [7:0]          data_lock_reg;
  logic [7:0]          config_lock_reg;

  function automatic logic [CREDIT_W-1:0] clear_lowest(input logic [CREDIT_W-1:0] v);
    clear_lowest = v & (v - CREDIT_W'(1));
  endfunction : clear_lowest

  function automatic logic in_range(input logic [4:0] w, input logic [4:0] lo, input logic [4:0] hi);
    in_range = (w >= lo) && (w <= hi);
  endfunction : in_range

  // Lock state.
  wire logic data_lck = (data_lock_reg != LOCK_OPEN);
  wire logic cfg_lck  = (config_lock_reg != LOCK_OPEN);

  // Policy of the addressed slot.
  wire logic [15:0] cfg_sel = slot_cfg_reg[CMD_SLOT_I];
  logic       secret;
  logic       enc_read;
  logic       use_limit;
  logic       verify_only;
  logic [3:0] wkey;
  logic [3:0] rkey;
  logic       wr_always;
  logic       wr_never;
  logic       wr_encrypt;
  logic       dk_allowed;
  logic       dk_create;
  logic       dk_mac_req;
  logic       copy_src;

  sapd_field_decode u_decode (
    .cfg_i         (cfg_sel),
    .secret_o      (secret),
    .enc_read_o    (enc_read),
    .use_limit_o   (use_limit),
    .verify_only_o (verify_only),
    .wkey_o        (wkey),
    .rkey_o        (rkey),
    .wr_always_o   (wr_always),
    .wr_never_o    (wr_never),
    .wr_encrypt_o  (wr_encrypt),
    .dk_allowed_o  (dk_allowed),
    .dk_create_o   (dk_create),
    .dk_mac_req_o  (dk_mac_req),
    .copy_src_o    (copy_src)
  );

  // Use credits of the addressed slot; slot 15 draws on the long vector.
  wire logic has_credit = (CMD_SLOT_I < 4'(LIMITED_SLOTS)) || (CMD_SLOT_I == LAST_USE_SLOT);
  wire logic [CREDIT_W-1:0] last_use_flat = {last_use_reg[3], last_use_reg[2],
                                             last_use_reg[1], last_use_reg[0]};
  wire logic [CREDIT_W-1:0] credit_vec = (CMD_SLOT_I == LAST_USE_SLOT) ? last_use_flat :
                                         {120'h0, credit_reg[CMD_SLOT_I[2:0]]};
  logic [7:0] uses_left;

  sapd_bit_count #(.WIDTH(CREDIT_W), .CNT_W(8)) u_count (
    .vec_i   (credit_vec),
    .count_o (uses_left)
  );

  wire logic limited   = use_limit && has_credit;
  wire logic credit_ok = !limited || (uses_left != 8'h00);
  wire logic [CREDIT_W-1:0] credit_after = clear_lowest(credit_vec);

  // Read: non-secret slots give clear reads unless encrypted-read is set;
  // secret slots need encrypted-read, an encrypted command and 32 bytes.
  wire logic rd_ok = cfg_lck && data_lck &&
                     (!secret ? (!enc_read && !CMD_ENCRYPTED_I) :
                      (enc_read && CMD_ENCRYPTED_I && CMD_LONG_I));

  // Write: free once config is locked and while data is open, then by the write policy.
  wire logic wr_pol_ok = (wr_always && !secret && !CMD_ENCRYPTED_I) ||
                         (wr_encrypt && CMD_ENCRYPTED_I && CMD_MAC_OK_I &&
                          CMD_LONG_I);
  wire logic wr_ok = cfg_lck && (!data_lck ||
                     (!wr_never && wr_pol_ok &&
                      !(secret && !CMD_LONG_I)));

  // Key derivation on the target slot.
  wire logic dk_ok = cfg_lck && data_lck && secret && dk_allowed &&
                     (!dk_mac_req || CMD_MAC_OK_I) &&
                     !verify_only && credit_ok;
  wire logic [3:0] dk_key = dk_create ? wkey : CMD_SLOT_I;

  // Key use by crypto commands.
  wire logic cmd_verify_ok = (CMD_OP_I == OP_VERIFY) ||
                             ((CMD_OP_I == OP_DIGEST) && CMD_VERIFY_NEXT_I);
  wire logic key_ok = cfg_lck && data_lck && secret && credit_ok &&
                      (!verify_only || cmd_verify_ok);
  wire logic copy_ok = cfg_lck && data_lck && copy_src && CMD_MAC_OK_I;

  // Configuration zone.
  wire logic cfg_wr_ok = !cfg_lck && in_range(CMD_WORD_I, W_SLOT_FIRST, W_LASTUSE_LAST);
  logic [31:0] cfg_rdata;
  always_comb begin
    cfg_rdata = 32'h0;
    if (in_range(CMD_WORD_I, W_SLOT_FIRST, W_SLOT_LAST)) begin
      cfg_rdata = {slot_cfg_reg[{CMD_WORD_I[2:0] - 3'h5, 1'b1}],
                   slot_cfg_reg[{CMD_WORD_I[2:0] - 3'h5, 1'b0}]};
    end else if (in_range(CMD_WORD_I, W_CREDIT_FIRST, W_CREDIT_LAST)) begin
      cfg_rdata = {8'h00, credit_reg[{CMD_WORD_I[1:0] - 2'h1, 1'b1}],
                   8'h00, credit_reg[{CMD_WORD_I[1:0] - 2'h1, 1'b0}]};
    end else if (in_range(CMD_WORD_I, W_LASTUSE_FIRST, W_LASTUSE_LAST)) begin
      cfg_rdata = last_use_reg[CMD_WORD_I[1:0] - 2'h1];
    end else if (CMD_WORD_I == W_LOCK) begin
      cfg_rdata = {config_lock_reg, data_lock_reg, 16'h0000};
    end
  end

  // Grant and key selection per command.
  logic       grant;
  logic [3:0] key_slot;
  always_comb begin
    grant    = 1'b0;
    key_slot = CMD_SLOT_I;
    case (CMD_OP_I)
      OP_READ: begin
        grant    = rd_ok;
        key_slot = rkey;
      end
      OP_WRITE: begin
        grant    = wr_ok;
        key_slot = wkey;
      end
      OP_DERIVE: begin
        grant    = dk_ok;
        key_slot = dk_key;
      end
      OP_VERIFY, OP_DIGEST, OP_MAC: begin
        grant    = key_ok;
      end
      OP_COPY:      grant = copy_ok;
      OP_CFG_READ:  grant = 1'b1;
      OP_CFG_WRITE: grant = cfg_wr_ok;
      OP_LOCK_CFG:  grant = !cfg_lck;
      OP_LOCK_DATA: grant = cfg_lck && !data_lck;
      default:      grant = 1'b0;
    endcase
  end

  wire logic is_key_use = (CMD_OP_I == OP_DERIVE) || (CMD_OP_I == OP_VERIFY) ||
                          (CMD_OP_I == OP_DIGEST) || (CMD_OP_I == OP_MAC);
  wire logic do_grant   = CMD_VALID_I && grant;
  wire logic consume    = do_grant && is_key_use && limited;
  wire logic cfg_write  = do_grant && (CMD_OP_I == OP_CFG_WRITE);

  // Storage updates; nothing changes on a refused command.
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_cfg_reg[i] <= SLOT_CFG_RST;
      end
      for (int i = 0; i < LIMITED_SLOTS; i++) begin
        credit_reg[i] <= CREDIT_RST;
      end
      for (int i = 0; i < 4; i++) begin
        last_use_reg[i] <= LASTUSE_RST;
      end
    end else if (cfg_write) begin
      if (in_range(CMD_WORD_I, W_SLOT_FIRST, W_SLOT_LAST)) begin
        slot_cfg_reg[{CMD_WORD_I[2:0] - 3'h5, 1'b0}] <= CMD_WDATA_I[15:0];
        slot_cfg_reg[{CMD_WORD_I[2:0] - 3'h5, 1'b1}] <= CMD_WDATA_I[31:16];
      end else if (in_range(CMD_WORD_I, W_CREDIT_FIRST, W_CREDIT_LAST)) begin
        credit_reg[{CMD_WORD_I[1:0] - 2'h1, 1'b0}] <= CMD_WDATA_I[7:0];
        credit_reg[{CMD_WORD_I[1:0] - 2'h1, 1'b1}] <= CMD_WDATA_I[23:16];
      end else begin
        last_use_reg[CMD_WORD_I[1:0] - 2'h1] <= CMD_WDATA_I;
      end
    end else if (consume) begin
      if (CMD_SLOT_I == LAST_USE_SLOT) begin
        for (int i = 0; i < 4; i++) begin
          last_use_reg[i] <= credit_after[32*i +: 32];
        end
      end else begin
        credit_reg[CMD_SLOT_I[2:0]] <= credit_after[7:0];
      end
    end
  end

  // Lock bytes only ever move from open to shut.
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      data_lock_reg   <= LOCK_OPEN;
      config_lock_reg <= LOCK_OPEN;
    end else if (do_grant && (CMD_OP_I == OP_LOCK_CFG)) begin
      config_lock_reg <= LOCK_SHUT;
    end else if (do_grant && (CMD_OP_I == OP_LOCK_DATA)) begin
      data_lock_reg   <= LOCK_SHUT;
    end
  end

  // Registered answer, one cycle after the command.
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      RSP_VALID_O     <= 1'b0;
      RSP_GRANT_O     <= 1'b0;
      RSP_ERROR_O     <= 1'b0;
      RSP_KEY_SLOT_O  <= 4'h0;
      RSP_MAC_REQ_O   <= 1'b0;
      RSP_CREATE_O    <= 1'b0;
      RSP_USES_LEFT_O <= 8'h00;
      RSP_RDATA_O     <= 32'h0;
      DATA_LOCKED_O   <= 1'b0;
      CONFIG_LOCKED_O <= 1'b0;
    end else begin
      RSP_VALID_O     <= CMD_VALID_I;
      RSP_GRANT_O     <= do_grant;
      RSP_ERROR_O     <= CMD_VALID_I && !grant;
      RSP_KEY_SLOT_O  <= key_slot;
      RSP_MAC_REQ_O   <= dk_mac_req && (CMD_OP_I == OP_DERIVE);
      RSP_CREATE_O    <= dk_create && (CMD_OP_I == OP_DERIVE);
      RSP_USES_LEFT_O <= uses_left;
      RSP_RDATA_O     <= (do_grant && (CMD_OP_I == OP_CFG_READ)) ? cfg_rdata : 32'h0;
      DATA_LOCKED_O   <= data_lck;
      CONFIG_LOCKED_O <= cfg_lck;
    end
  end

  // All slot configuration words as one vector, so the lock check can compare them.
  logic [16*NUM_SLOTS-1:0] slot_cfg_flat;
  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      slot_cfg_flat[16*i +: 16] = slot_cfg_reg[i];
    end
  end

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  a_read_open_refused: assert property (
    CMD_VALID_I && CMD_OP_I == OP_READ && !data_lck |=> RSP_VALID_O && RSP_ERROR_O)
    else $error("read of an unlocked data zone was granted");

  a_write_open_taken: assert property (
    CMD_VALID_I && CMD_OP_I == OP_WRITE && cfg_lck && !data_lck |=> RSP_GRANT_O)
    else $error("write to an unlocked data zone was refused");

  a_secret_short_access: assert property (
    CMD_VALID_I && (CMD_OP_I == OP_READ || CMD_OP_I == OP_WRITE) && data_lck &&
    secret && !CMD_LONG_I |=> !RSP_GRANT_O)
    else $error("short access to a secret slot was granted");

  a_never_write_blocked: assert property (
    CMD_VALID_I && CMD_OP_I == OP_WRITE && data_lck && wr_never |=> RSP_ERROR_O)
    else $error("write to a never-write slot was granted");

  a_derive_target_gate: assert property (
    CMD_VALID_I && CMD_OP_I == OP_DERIVE && !cfg_sel[WP_DK_BIT] |=> !RSP_GRANT_O)
    else $error("derivation into an ineligible slot was granted");

  a_derive_key_source: assert property (
    CMD_VALID_I && CMD_OP_I == OP_DERIVE |=>
    RSP_KEY_SLOT_O == ($past(cfg_sel[WP_CREATE_BIT]) ? $past(cfg_sel[WKEY_HI:WKEY_LO]) :
                       $past(CMD_SLOT_I)))
    else $error("derivation source key slot is wrong");

  a_verify_only_mac: assert property (
    CMD_VALID_I && CMD_OP_I == OP_MAC && verify_only |=> RSP_VALID_O && !RSP_GRANT_O)
    else $error("verify-only slot served a plain MAC command");

  a_cfg_locked_write: assert property (
    CMD_VALID_I && CMD_OP_I == OP_CFG_WRITE && cfg_lck |=>
    !RSP_GRANT_O && slot_cfg_flat == $past(slot_cfg_flat))
    else $error("configuration changed while locked");

  a_credit_consumed: assert property (
    consume && CMD_SLOT_I < 4'(LIMITED_SLOTS) |=>
    $countones(credit_reg[$past(CMD_SLOT_I[2:0])]) == $past(uses_left) - 8'h01)
    else $error("limited-use credit was not reduced by one");

  a_exhausted_refused: assert property (
    CMD_VALID_I && is_key_use && limited && uses_left == 8'h00 |=> RSP_ERROR_O ##1 1'b1)
    else $error("slot with no credit left was used");

  a_answer_one_hot: assert property (
    CMD_VALID_I |=> RSP_VALID_O && (RSP_GRANT_O != RSP_ERROR_O))
    else $error("answer was not exactly one of grant and error");

  a_enc_read_secret: assert property (
    CMD_VALID_I && CMD_OP_I == OP_READ && enc_read && !secret |=> RSP_ERROR_O)
    else $error("encrypted-read slot without secret flag was read");

  a_always_clear_write: assert property (
    CMD_VALID_I && CMD_OP_I == OP_WRITE && cfg_lck && data_lck && wr_always &&
    !secret && !CMD_ENCRYPTED_I |=> RSP_GRANT_O)
    else $error("clear write to an always-writable slot was refused");

  a_data_lock_sticky: assert property (
    DATA_LOCKED_O |=> DATA_LOCKED_O)
    else $error("locked data zone became unlocked");

endmodule : sapd_top

/* tb_top.sv */
/*
  Self-checking testbench for the slot access policy decoder.
  Assumes the host model drives the command port and answers are registered at the taking edge and read at the next falling edge.
*/
`timescale 1ns/1ps
module tb_top;
  import sapd_pkg::*;
  logic        clk;
  logic        srst;
  logic        c_valid, c_long, c_enc, c_mac, c_vn;
  sapd_op_t    c_op;
  logic [3:0]  c_slot, r_key;
  logic [4:0]  c_word;
  logic [31:0] c_wdata, r_rdata;
  logic        r_valid, r_grant, r_err, r_mac, r_create, d_lock, c_lock;
  logic [7:0]  r_uses;
  int          err_count = 0;
  int          n_compared = 0;
  int          i;

  sapd_host_model host (.clk_i(clk), .cmd_valid_o(c_valid), .cmd_op_o(c_op), .cmd_slot_o(c_slot),
    .cmd_long_o(c_long), .cmd_enc_o(c_enc), .cmd_mac_ok_o(c_mac), .cmd_vnext_o(c_vn),
    .cmd_word_o(c_word), .cmd_wdata_o(c_wdata));

  sapd_top DUT (.MCLK_I(clk), .SRST_I(srst), .CMD_VALID_I(c_valid), .CMD_OP_I(c_op), .CMD_SLOT_I(c_slot),
    .CMD_LONG_I(c_long), .CMD_ENCRYPTED_I(c_enc), .CMD_MAC_OK_I(c_mac), .CMD_VERIFY_NEXT_I(c_vn),
    .CMD_WORD_I(c_word), .CMD_WDATA_I(c_wdata), .RSP_VALID_O(r_valid), .RSP_GRANT_O(r_grant),
    .RSP_ERROR_O(r_err), .RSP_KEY_SLOT_O(r_key), .RSP_MAC_REQ_O(r_mac), .RSP_CREATE_O(r_create),
    .RSP_USES_LEFT_O(r_uses), .RSP_RDATA_O(r_rdata), .DATA_LOCKED_O(d_lock), .CONFIG_LOCKED_O(c_lock));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_val

  task automatic chk_rsp(input string nm, input logic g);
    n_compared++;
    if ({r_valid, r_grant, r_err} !== {1'b1, g, ~g}) begin
      err_count++;
      $display("BAD %s expected grant %b seen valid %b grant %b error %b", nm, g, r_valid, r_grant, r_err);
    end
  endtask : chk_rsp

  // Flags are long, encrypted, MAC good, verify next; a key of 5'h10 is not compared.
  task automatic tx(input sapd_op_t op, input logic [3:0] s, input logic [3:0] fl, input logic g,
                    input logic [4:0] k);
    host.send(op, s, fl, 5'h00, 32'h0);
    chk_rsp(op.name(), g);
    if (g && !k[4]) begin
      chk_val("key slot", {28'h0, k[3:0]}, {28'h0, r_key});
    end
  endtask : tx

  task automatic cfg(input sapd_op_t op, input logic [4:0] w, input logic [31:0] d, input logic g);
    host.send(op, 4'h0, 4'h0, w, d);
    chk_rsp(op.name(), g);
  endtask : cfg

  initial begin
    #50000;
    err_count++;
    $display("BAD watchdog expected finish seen timeout");
    close_out();
  end

  initial begin
    srst = 1'b1;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk_val("locks", 32'h0, {30'h0, c_lock, d_lock});
    cfg(OP_CFG_READ, 5'h15, 32'h0, 1'b1);
    chk_val("lock word", 32'h5555_0000, r_rdata);
    tx(OP_READ, 4'h0, 4'b1000, 1'b0, 5'h10);
    cfg(OP_CFG_WRITE, 5'h05, 32'h2180_0000, 1'b1);
    cfg(OP_CFG_WRITE, 5'h06, 32'h80c5_4283, 1'b1);
    cfg(OP_CFG_WRITE, 5'h07, 32'h6580_b6a0, 1'b1);
    cfg(OP_CFG_WRITE, 5'h08, 32'h0040_8090, 1'b1);
    cfg(OP_CFG_READ, 5'h07, 32'h0, 1'b1);
    chk_val("slot word", 32'h6580_b6a0, r_rdata);
    cfg(OP_LOCK_CFG, 5'h00, 32'h0, 1'b1);
    @(negedge clk);
    chk_val("config lock", 32'h1, {31'h0, c_lock});
    cfg(OP_CFG_WRITE, 5'h05, 32'hffff_ffff, 1'b0);
    cfg(OP_CFG_READ, 5'h05, 32'h0, 1'b1);
    chk_val("slot word", 32'h2180_0000, r_rdata);
    tx(OP_WRITE, 4'h1, 4'b1000, 1'b1, 5'h10);
    tx(OP_DERIVE, 4'h1, 4'b0010, 1'b0, 5'h10);
    cfg(OP_LOCK_DATA, 5'h00, 32'h0, 1'b1);
    @(negedge clk);
    chk_val("data lock", 32'h1, {31'h0, d_lock});
    tx(OP_READ, 4'h0, 4'b0000, 1'b1, 5'h00);
    tx(OP_READ, 4'h7, 4'b1000, 1'b0, 5'h10);
    tx(OP_READ, 4'h3, 4'b1100, 1'b1, 5'h05);
    tx(OP_READ, 4'h3, 4'b0100, 1'b0, 5'h10);
    tx(OP_READ, 4'h3, 4'b1000, 1'b0, 5'h10);
    tx(OP_READ, 4'h2, 4'b1100, 1'b0, 5'h10);
    tx(OP_WRITE, 4'h0, 4'b0000, 1'b1, 5'h10);
    tx(OP_WRITE, 4'h0, 4'b1000, 1'b1, 5'h10);
    tx(OP_WRITE, 4'h1, 4'b1110, 1'b0, 5'h10);
    tx(OP_WRITE, 4'h3, 4'b1110, 1'b0, 5'h10);
    tx(OP_WRITE, 4'h2, 4'b1110, 1'b1, 5'h02);
    tx(OP_WRITE, 4'h2, 4'b1100, 1'b0, 5'h10);
    tx(OP_WRITE, 4'h2, 4'b0110, 1'b0, 5'h10);
    tx(OP_WRITE, 4'h2, 4'b1010, 1'b0, 5'h10);
    tx(OP_WRITE, 4'h5, 4'b1110, 1'b1, 5'h05);
    tx(OP_DERIVE, 4'h1, 4'b0000, 1'b1, 5'h01);
    chk_val("mac and create", 32'h0, {30'h0, r_mac, r_create});
    tx(OP_DERIVE, 4'h5, 4'b0000, 1'b1, 5'h05);
    tx(OP_DERIVE, 4'h3, 4'b0010, 1'b0, 5'h10);
    tx(OP_DERIVE, 4'h0, 4'b0010, 1'b0, 5'h10);
    tx(OP_DERIVE, 4'h4, 4'b0000, 1'b0, 5'h10);
    for (i = 0; i < 9; i++) begin
      tx(OP_DERIVE, 4'h4, 4'b0010, i < 8, 5'h06);
      chk_val("uses left", 32'(8 - i), {24'h0, r_uses});
      if (i < 8) begin
        chk_val("mac and create", 32'h3, {30'h0, r_mac, r_create});
      end
    end
    tx(OP_VERIFY, 4'h6, 4'b0000, 1'b1, 5'h10);
    tx(OP_DIGEST, 4'h6, 4'b0001, 1'b1, 5'h10);
    tx(OP_DIGEST, 4'h6, 4'b0000, 1'b0, 5'h10);
    tx(OP_MAC, 4'h6, 4'b0000, 1'b0, 5'h10);
    tx(OP_MAC, 4'h2, 4'b0000, 1'b1, 5'h10);
    tx(OP_VERIFY, 4'h0, 4'b0000, 1'b0, 5'h10);
    tx(OP_COPY, 4'h0, 4'b0010, 1'b1, 5'h10);
    tx(OP_COPY, 4'h3, 4'b0010, 1'b0, 5'h10);
    tx(sapd_op_t'(4'hf), 4'h0, 4'b0000, 1'b0, 5'h10);
    cfg(OP_CFG_READ, 5'h0f, 32'h0, 1'b1);
    chk_val("credits", 32'h00ff_0000, r_rdata & 32'h00ff_00ff);
    close_out();
  end
endmodule : tb_top
